// *** verilog/udpc_device.sv ***
// device end: ultra sleep entry and wake, page size configuration
`timescale 1ns/10ps
`default_nettype none
module udpc_device #(
    parameter int ENTRY_CYCLES = udpc_pkg::ENTRY_CYC,
    parameter int EXIT_CYCLES  = udpc_pkg::EXIT_CYC,
    parameter int PROG_CYCLES  = udpc_pkg::PROG_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    udpc_if.device    link,
    input  wire logic busy_other,
    output logic      ready,
    output logic      page_binary,
    output logic      ultra_sleep,
    output logic      buffers_lost
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] cs_sync_reg;
    logic [1:0] sck_sync_reg;
    logic [1:0] mosi_sync_reg;
    logic       sck_last_reg;
    logic       cs_last_reg;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cs_sync_reg   <= 2'h3;
            sck_sync_reg  <= 2'h0;
            mosi_sync_reg <= 2'h0;
            sck_last_reg  <= 1'b0;
            cs_last_reg   <= 1'b1;
        end else begin
            cs_sync_reg   <= {cs_sync_reg[0], link.cs_n};
            sck_sync_reg  <= {sck_sync_reg[0], link.sck};
            mosi_sync_reg <= {mosi_sync_reg[0], link.mosi};
            sck_last_reg  <= sck_sync_reg[1];
            cs_last_reg   <= cs_sync_reg[1];
        end
    end
    logic cs_n_s;
    logic sck_rise;
    logic cs_rise;
    logic cs_fall;
    assign cs_n_s   = cs_sync_reg[1];
    assign sck_rise = sck_sync_reg[1] & ~sck_last_reg & ~cs_n_s;
    assign cs_rise  = cs_n_s & ~cs_last_reg;
    assign cs_fall  = ~cs_n_s & cs_last_reg;

    assign link.miso    = 1'b0;
    assign link.miso_oe = 1'b0;

    // ------------------------------------------------------------
    // frame shifter: bits counted mod 8, bytes counted to five
    // ------------------------------------------------------------
    udpc_pkg::udpc_pwr_t pwr_reg;
    logic [7:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic [2:0] byte_cnt_reg;
    logic       frame_ok_reg;  // bytes up to the third match a known command; the fourth is judged by is_cfg_reg
    logic       is_sleep_reg;
    logic       is_cfg_reg;
    logic       cfg_bin_reg;
    logic       frame_live_reg; // frame started while device could listen
    logic [7:0] byte_in;
    assign byte_in = {shift_reg[6:0], mosi_sync_reg[1]};
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            shift_reg      <= 8'h00;
            bit_cnt_reg    <= 3'h0;
            byte_cnt_reg   <= 3'h0;
            frame_ok_reg   <= 1'b0;
            is_sleep_reg   <= 1'b0;
            is_cfg_reg     <= 1'b0;
            cfg_bin_reg    <= 1'b0;
            frame_live_reg <= 1'b0;
        end else if (cs_fall) begin
            bit_cnt_reg    <= 3'h0;
            byte_cnt_reg   <= 3'h0;
            frame_ok_reg   <= 1'b1;
            is_sleep_reg   <= 1'b0;
            is_cfg_reg     <= 1'b0;
            // frames begun outside standby (entering, asleep or waking) are dead (see R2) (see R9) (see R10)
            frame_live_reg <= (pwr_reg == udpc_pkg::UDPC_STANDBY);
        end else if (sck_rise && frame_live_reg) begin
            shift_reg   <= byte_in;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7 && !is_sleep_reg && frame_ok_reg) begin
                // after the entry opcode extra bytes are ignored (see R4)
                byte_cnt_reg <= byte_cnt_reg + 3'h1;
                case (byte_cnt_reg)
                    3'h0: begin
                        is_sleep_reg <= (byte_in == udpc_pkg::OP_ULTRA_SLEEP); // see R1
                        frame_ok_reg <= (byte_in == udpc_pkg::OP_ULTRA_SLEEP)
                                      | (byte_in == udpc_pkg::OP_CFG_B1);
                    end
                    3'h1: frame_ok_reg <= (byte_in == udpc_pkg::OP_CFG_B2);
                    3'h2: frame_ok_reg <= (byte_in == udpc_pkg::OP_CFG_B3);
                    3'h3: begin
                        // see R14 see R15
                        is_cfg_reg  <= (byte_in == udpc_pkg::OP_CFG_BINARY)
                                     | (byte_in == udpc_pkg::OP_CFG_STD);
                        cfg_bin_reg <= (byte_in == udpc_pkg::OP_CFG_BINARY);
                    end
                    default: begin
                        // a fifth byte spoils a size sequence (see R21)
                        is_cfg_reg   <= 1'b0;
                        frame_ok_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // only whole-byte frames with a complete command act (see R6) (see R21)
    logic go_sleep;
    logic go_cfg;
    logic whole;
    assign whole    = cs_rise && frame_live_reg && frame_ok_reg && bit_cnt_reg == 3'h0;
    assign go_sleep = whole && is_sleep_reg && ready;   // see R7
    assign go_cfg   = whole && is_cfg_reg && ready;

    // ------------------------------------------------------------
    // power state and program timer
    // ------------------------------------------------------------
    logic [31:0] pwr_cnt_reg;
    logic [31:0] prog_cnt_reg;
    logic        prog_busy_reg;
    logic        prog_bin_reg;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pwr_reg     <= udpc_pkg::UDPC_STANDBY; // see R11
            pwr_cnt_reg <= 32'h0;
        end else begin
            case (pwr_reg)
                udpc_pkg::UDPC_STANDBY: if (go_sleep) begin
                    pwr_reg     <= udpc_pkg::UDPC_ENTERING;
                    pwr_cnt_reg <= 32'h0;
                end
                udpc_pkg::UDPC_ENTERING: begin
                    pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
                    if (pwr_cnt_reg >= 32'(ENTRY_CYCLES - 1)) begin
                        pwr_reg <= udpc_pkg::UDPC_SLEEP; // see R5
                    end
                end
                udpc_pkg::UDPC_SLEEP: if (cs_rise) begin
                    // a low pulse on chip select that the synchroniser samples wakes, bytes are discarded (see R9)
                    pwr_reg     <= udpc_pkg::UDPC_WAKING;
                    pwr_cnt_reg <= 32'h0;
                end
                udpc_pkg::UDPC_WAKING: begin
                    pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
                    if (pwr_cnt_reg >= 32'(EXIT_CYCLES - 1)) begin
                        pwr_reg <= udpc_pkg::UDPC_STANDBY; // see R10
                    end
                end
                default: pwr_reg <= udpc_pkg::UDPC_STANDBY;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            buffers_lost <= 1'b0;
        end else if (pwr_reg == udpc_pkg::UDPC_ENTERING) begin
            // flagged on the way down so the sleep state never shows with live buffers
            buffers_lost <= 1'b1; // see R3
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            prog_busy_reg <= 1'b0;
            prog_cnt_reg  <= 32'h0;
            prog_bin_reg  <= 1'b0;
        end else if (go_cfg) begin
            prog_busy_reg <= 1'b1; // see R16
            prog_cnt_reg  <= 32'h0;
            prog_bin_reg  <= cfg_bin_reg;
        end else if (prog_busy_reg) begin
            prog_cnt_reg <= prog_cnt_reg + 32'h1;
            if (prog_cnt_reg >= 32'(PROG_CYCLES - 1)) begin
                prog_busy_reg <= 1'b0;
            end
        end
    end

    // power-on marker: only the first reset loads the shipped size, later resets keep it
    logic nv_init_reg = 1'b0;
    // stands in for the nonvolatile cell
    always_ff @(posedge sys_clk) begin
        if (!rstn && !nv_init_reg) begin
            page_binary <= udpc_pkg::PAGE_BINARY_RESET; // see R13
        end else if (prog_busy_reg && prog_cnt_reg >= 32'(PROG_CYCLES - 1)) begin
            page_binary <= prog_bin_reg; // see R17 see R12 see R20
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            nv_init_reg <= 1'b1;
        end
    end

    assign ready = ~prog_busy_reg & ~busy_other; // see R19
    assign ultra_sleep = (pwr_reg == udpc_pkg::UDPC_SLEEP);
endmodule
`default_nettype wire

// *** verilog/udpc_pkg.sv ***
// package: opcodes, timing and layout constants for the ultra sleep / page size command block
// Function
// R1 - opcode 79h then chip select rise: ultra sleep
// R2 - in ultra sleep every command ignored
// R3 - entering ultra sleep discards buffer contents
// R4 - bits after entry opcode are ignored
// R5 - enter ultra sleep within maximum entry delay
// R6 - short or ragged frame aborts, stay standby
// R7 - entry ignored while program cycle busy
// R8 - wake: chip select low minimum pulse time
// R9 - byte shifted during wake pulse ignored
// R10 - ready within exit delay, earlier frames ignored
// R11 - reset always starts in standby
// R12 - page is 528 standard, 512 binary bytes
// R13 - default page size is 528 bytes
// R14 - 3Dh 2Ah 80h A6h selects 512 bytes
// R15 - 3Dh 2Ah 80h A7h selects 528 bytes
// R16 - frame end starts timed program, busy shown
// R17 - new size applies after program, kept nonvolatile
// R18 - host limits size changes to 10,000; udpc_host keeps no count and MAX_SIZE_CHANGES is unused
// R19 - ready flag 0 busy, 1 done
// R20 - status bit shows binary or standard size
// R21 - bad size sequence changes nothing, no program
package udpc_pkg;
    localparam logic [7:0] OP_ULTRA_SLEEP = 8'h79;
    localparam logic [7:0] OP_CFG_B1      = 8'h3d;
    localparam logic [7:0] OP_CFG_B2      = 8'h2a;
    localparam logic [7:0] OP_CFG_B3      = 8'h80;
    localparam logic [7:0] OP_CFG_BINARY  = 8'ha6;
    localparam logic [7:0] OP_CFG_STD     = 8'ha7;
    localparam int PAGE_STD_BYTES    = 528;
    localparam int PAGE_BIN_BYTES    = 512;
    localparam int PAGE_EXTRA_BYTES  = 16;
    localparam logic PAGE_BINARY_RESET = 1'b0;
    localparam int SYS_CLK_NS        = 50;
    localparam int ENTRY_DELAY_NS    = 3000;  // ultra_sleep_entry_delay, longest
    localparam int WAKE_MIN_LOW_NS   = 20;    // wake_pulse_min_low, least
    localparam int EXIT_DELAY_NS     = 120000; // ultra_sleep_exit_delay, longest
    localparam int PROGRAM_TIME_NS   = 1000000; // config_program_time
    localparam int ENTRY_CYC = (ENTRY_DELAY_NS / SYS_CLK_NS) < 1 ? 1
                             : ENTRY_DELAY_NS / SYS_CLK_NS;
    localparam int WAKE_CYC  = (WAKE_MIN_LOW_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int EXIT_CYC  = (EXIT_DELAY_NS / SYS_CLK_NS) < 1 ? 1
                             : EXIT_DELAY_NS / SYS_CLK_NS;
    localparam int PROG_CYC  = PROGRAM_TIME_NS / SYS_CLK_NS;
    localparam int SCK_HALF_CYC = 4;
    localparam int MAX_SIZE_CHANGES = 10000;
    typedef enum {UDPC_STANDBY, UDPC_ENTERING, UDPC_SLEEP, UDPC_WAKING} udpc_pwr_t;
    typedef enum {UDPC_H_IDLE, UDPC_H_SHIFT, UDPC_H_GAP, UDPC_H_WAKE} udpc_hst_t;
endpackage

// *** verilog/udpc_if.sv ***
// interface: the serial link between host and device
`timescale 1ns/10ps
`default_nettype none
interface udpc_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    modport device (input cs_n, input sck, input mosi, output miso, output miso_oe);
    modport host   (output cs_n, output sck, output mosi, input miso, input miso_oe);
endinterface
`default_nettype wire

// *** verilog/udpc_host.sv ***
// host end: shifts command frames and wake pulses onto the link
`timescale 1ns/10ps
`default_nettype none
module udpc_host #(
    parameter int HALF_CYCLES = udpc_pkg::SCK_HALF_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    udpc_if.host            link,
    input  wire logic       cmd_valid,
    input  wire logic [2:0] cmd_bytes,
    input  wire logic [31:0] cmd_data,
    input  wire logic       cmd_wake,
    output logic            cmd_ready
);
    udpc_pkg::udpc_hst_t st_reg;
    logic [31:0] data_reg;
    logic [5:0]  bits_reg;
    logic [7:0]  div_reg;
    logic        sck_reg;
    logic        cs_n_reg;
    logic        tick;
    assign tick = (div_reg == 8'(HALF_CYCLES - 1));
    always_ff @(posedge sys_clk) begin
        if (!rstn || st_reg == udpc_pkg::UDPC_H_IDLE || tick) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_reg   <= udpc_pkg::UDPC_H_IDLE;
            cs_n_reg <= 1'b1;
            sck_reg  <= 1'b0;
            data_reg <= 32'h0;
            bits_reg <= 6'h0;
        end else begin
            case (st_reg)
                udpc_pkg::UDPC_H_IDLE: if (cmd_valid) begin
                    cs_n_reg <= 1'b0;
                    data_reg <= cmd_data;
                    bits_reg <= 6'({cmd_bytes, 3'h0});
                    // wake pulse held low several sys periods (see R8)
                    st_reg   <= cmd_wake ? udpc_pkg::UDPC_H_WAKE : udpc_pkg::UDPC_H_SHIFT;
                end
                udpc_pkg::UDPC_H_WAKE: if (tick) begin
                    cs_n_reg <= 1'b1;
                    st_reg   <= udpc_pkg::UDPC_H_GAP;
                end
                udpc_pkg::UDPC_H_SHIFT: if (tick) begin
                    if (bits_reg == 6'h0) begin
                        cs_n_reg <= 1'b1; // see R1 see R14 see R15
                        st_reg   <= udpc_pkg::UDPC_H_GAP;
                    end else if (!sck_reg) begin
                        sck_reg <= 1'b1;
                    end else begin
                        sck_reg  <= 1'b0;
                        data_reg <= {data_reg[30:0], 1'b0};
                        bits_reg <= bits_reg - 6'h1;
                    end
                end
                udpc_pkg::UDPC_H_GAP: if (tick) begin
                    st_reg <= udpc_pkg::UDPC_H_IDLE;
                end
                default: st_reg <= udpc_pkg::UDPC_H_IDLE;
            endcase
        end
    end
    assign cmd_ready = (st_reg == udpc_pkg::UDPC_H_IDLE);
    assign link.cs_n = cs_n_reg;
    assign link.sck  = sck_reg;
    assign link.mosi = data_reg[31];
endmodule
`default_nettype wire

// *** testbench/udpc_properties.sv ***
// checker: link framing and device state properties of the sleep / page size block
`timescale 1ns/10ps
`default_nettype none
module udpc_properties (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic busy_other,
    input wire logic ready,
    input wire logic page_binary,
    input wire logic ultra_sleep,
    input wire logic buffers_lost
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    chk_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("sck moves outside a frame");
    chk_sck_half_period: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
        else $error("sck high phase not four cycles");
    chk_mosi_on_low: assert property ((!cs_n && $changed(mosi)) |-> !sck)
        else $error("mosi changed while sck high");
    chk_miso_released: assert property (!miso_oe)
        else $error("device drove miso");
    chk_sleep_loses_buffers: assert property (ultra_sleep |-> buffers_lost)
        else $error("sleep without buffer loss flag");
    chk_sleep_after_cs: assert property ($rose(ultra_sleep) |-> cs_n && $past(cs_n, 4))
        else $error("sleep entered without frame end");
    chk_wake_after_pulse: assert property ($fell(ultra_sleep) |-> cs_n)
        else $error("sleep left while chip select low");
    chk_size_at_done: assert property ($changed(page_binary) |-> !$past(ready))
        else $error("page size changed outside a program cycle");
    chk_other_busy_shown: assert property (busy_other ##1 busy_other |-> !ready)
        else $error("ready high while other operation busy");
    chk_reset_standby: assert property ($rose(rstn) |-> !ultra_sleep && ready)
        else $error("device not in standby after reset");

    cover property ($rose(ultra_sleep));
    cover property ($fell(ultra_sleep));
    cover property ($changed(page_binary));
endmodule
`default_nettype wire

// *** testbench/udpc_device_tb_top.sv ***
// testbench: host and device ends joined by the link, driven through host commands
`timescale 1ns/10ps
`default_nettype none
module udpc_device_tb_top;
    localparam int ENT = 4;
    logic        sys_clk;
    logic        rstn;
    logic        busy_other;
    logic        ready;
    logic        page_binary;
    logic        ultra_sleep;
    logic        buffers_lost;
    logic        cmd_valid;
    logic [2:0]  cmd_bytes;
    logic [31:0] cmd_data;
    logic        cmd_wake;
    logic        cmd_ready;
    int          n_errors;
    int          check_count;
    int          cyc;
    int          lo_cnt;
    int          t_cs;
    int          t_sl;

    udpc_if link_if ();
    udpc_device #(.ENTRY_CYCLES(ENT), .EXIT_CYCLES(100), .PROG_CYCLES(16)) udpc_device_inst (
        .sys_clk(sys_clk), .rstn(rstn), .link(link_if), .busy_other(busy_other),
        .ready(ready), .page_binary(page_binary), .ultra_sleep(ultra_sleep),
        .buffers_lost(buffers_lost));
    udpc_host #(.HALF_CYCLES(4)) udpc_host_inst (
        .sys_clk(sys_clk), .rstn(rstn), .link(link_if), .cmd_valid(cmd_valid),
        .cmd_bytes(cmd_bytes), .cmd_data(cmd_data), .cmd_wake(cmd_wake),
        .cmd_ready(cmd_ready));
    udpc_properties udpc_properties_inst (
        .sys_clk(sys_clk), .rstn(rstn), .cs_n(link_if.cs_n), .sck(link_if.sck),
        .mosi(link_if.mosi), .miso(link_if.miso), .miso_oe(link_if.miso_oe),
        .busy_other(busy_other), .ready(ready), .page_binary(page_binary),
        .ultra_sleep(ultra_sleep), .buffers_lost(buffers_lost));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic complete_run();
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // entered at a falling edge; watches wc cycles after the command is taken
    task automatic xfer(input logic [2:0] nb, input logic [31:0] d, input logic wk,
                        input int wc);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        cmd_valid = 1'b1;
        cmd_bytes = nb;
        cmd_data  = d;
        cmd_wake  = wk;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        lo_cnt = 0;
        t_cs = 0;
        t_sl = -1;
        for (n = 0; n < wc; n++) begin
            @(negedge sys_clk);
            if (ready !== 1'b1) lo_cnt++;
            if (link_if.cs_n === 1'b0) t_cs = n;
            if (ultra_sleep === 1'b1 && t_sl < 0) t_sl = n;
        end
    endtask

    // ----------------------------------------
    // clock, timeout and sequence
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        n_errors = 0;
        check_count = 0;
        rstn = 1'b0;
        busy_other = 1'b0;
        cmd_valid = 1'b0;
        cmd_bytes = 3'h0;
        cmd_data = 32'h0;
        cmd_wake = 1'b0;
        repeat (10) @(negedge sys_clk);
        rstn = 1'b1;
        @(negedge sys_clk);
        check("ready", 1, ready);
        check("ultra_sleep", 0, ultra_sleep);
        check("page_binary", 0, page_binary);
        check("buffers_lost", 0, buffers_lost);
        xfer(3'h4, 32'h3d2a80a6, 1'b0, 360);
        check("busy_cycles", 1, lo_cnt >= 16 && lo_cnt <= 18);
        check("page_binary", 1, page_binary);
        // nonvolatile size must survive a second reset
        rstn = 1'b0;
        repeat (3) @(negedge sys_clk);
        rstn = 1'b1;
        @(negedge sys_clk);
        check("page_binary", 1, page_binary);
        xfer(3'h4, 32'h3d2a80a5, 1'b0, 360);
        check("busy_cycles", 0, lo_cnt);
        xfer(3'h3, 32'h3d2a8000, 1'b0, 360);
        check("busy_cycles", 0, lo_cnt);
        check("page_binary", 1, page_binary);
        xfer(3'h4, 32'h3d2a80a7, 1'b0, 360);
        check("busy_cycles", 1, lo_cnt >= 16 && lo_cnt <= 18);
        check("page_binary", 0, page_binary);
        xfer(3'h0, 32'h0, 1'b0, 60);
        check("ultra_sleep", 0, ultra_sleep);
        busy_other = 1'b1;
        xfer(3'h1, 32'h79000000, 1'b0, 100);
        busy_other = 1'b0;
        check("ultra_sleep", 0, ultra_sleep);
        xfer(3'h2, 32'h79a70000, 1'b0, 200);
        check("ultra_sleep", 1, ultra_sleep);
        check("buffers_lost", 1, buffers_lost);
        check("entry_delay", 1, t_sl - t_cs >= ENT && t_sl - t_cs <= ENT + 6);
        // a size frame while asleep only wakes the device
        xfer(3'h4, 32'h3d2a80a6, 1'b0, 360);
        check("page_binary", 0, page_binary);
        check("ultra_sleep", 0, ultra_sleep);
        xfer(3'h1, 32'h79000000, 1'b0, 100);
        check("ultra_sleep", 1, ultra_sleep);
        xfer(3'h0, 32'h0, 1'b1, 0);
        xfer(3'h4, 32'h3d2a80a6, 1'b0, 360);
        check("page_binary", 0, page_binary);
        check("ultra_sleep", 0, ultra_sleep);
        xfer(3'h4, 32'h3d2a80a6, 1'b0, 360);
        check("page_binary", 1, page_binary);
        check("ready", 1, ready);
        complete_run();
    end
endmodule
`default_nettype wire
